// ===== rtl/msp_cfg.svh
/*
  Constants of the master/slave PWM duty stepper: timing, duty steps,
  pin levels and reset values. Assumes a 100 MHz clock.
*/
`ifndef MSP_CFG_SVH
`define MSP_CFG_SVH

// Clock period of clk_i in nanoseconds.
`define MSP_CLK_NS 10
// PWM pulse cycle in nanoseconds (2 ms).
`define MSP_PERIOD_NS 2000000
// Pulse cycle in clock cycles, derived from the two figures above.
`define MSP_PERIOD_CYC (`MSP_PERIOD_NS / `MSP_CLK_NS)
// Width of the master and slave counters.
`define MSP_CNT_W 18
// Period interrupts per duty update (250 x 2 ms = 500 ms).
`define MSP_IRQ_PER_STEP 250
// Duty sequence: first value, increment and number of steps, in percent.
`define MSP_DUTY_FIRST_PCT 10
`define MSP_DUTY_STEP_PCT 20
`define MSP_DUTY_STEPS 5
`define MSP_FULL_PCT 100
// Compare value that gives 90% low width when the period is 64000 counts.
`define MSP_CMP_INIT_32M 16'hE100
// Pin levels: the output is active low.
`define MSP_PIN_IDLE 1'b1
`define MSP_PIN_ACTIVE 1'b0
// Reset level of the indicator pin.
`define MSP_IND_RESET 1'b0
// Both run-trigger bits set in one write.
`define MSP_TRIG_BOTH 2'h3

`endif

// ===== rtl/msp_pkg.sv
/*
  Types shared by the PWM duty stepper modules.
  Assumes msp_cfg.svh for the numeric constants.
*/
`default_nettype none

package msp_pkg;
  // Run state of the channel pair.
  typedef enum logic {ST_IDLE, ST_RUN} msp_state_type;
  // Index into the duty sequence.
  typedef logic [2:0] msp_step_type;
endpackage

`default_nettype wire

// ===== rtl/msp_pwm_top.sv
/*
  Master/slave PWM generator with a duty stepper and indicator pin.
  The master interval timer sets the pulse cycle and raises a period
  interrupt; the slave channel times the active-low width; every 250
  interrupts the duty advances and the indicator pin inverts.
  Assumes all inputs are synchronous to clk_i.
*/
`include "msp_cfg.svh"
`default_nettype none

// Function
// [RULE1] Master free-runs, 2 ms period.
// [RULE2] Slave one-shot, triggered each period start.
// [RULE3] Slave pin carries the PWM waveform.
// [RULE4] Active portion is a low level.
// [RULE5] Pin sits at 1 before counting.
// [RULE6] Initial low width is 90 percent.
// [RULE7] Start only when both triggers set together.
// [RULE8] Period interrupt every 2 ms.
// [RULE9] Every 250 interrupts update duty, restart count.
// [RULE10] Duty change writes slave compare value.
// [RULE11] Duty steps 10,30,50,70,90, wraps.
// [RULE12] Invert indicator pin at each update.
// [RULE13] Indicator pin enabled as output at init.
// [RULE14] Brightness is complement of the duty.
// [RULE15] Initial compare E100H at 64000 counts.
// [RULE16] Low width is period times complement; next-period effect.
// [RULE17] Period count is time times counting rate.
module msp_pwm_top
  import msp_pkg::*;
#(
  parameter int PERIOD_CYC = `MSP_PERIOD_CYC,
  parameter int CNT_W = `MSP_CNT_W,
  parameter int IRQ_PER_STEP = `MSP_IRQ_PER_STEP
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [1:0] run_trig_i,
  input wire logic halt_i,
  output logic pwm_out_pin_o,
  output logic master_period_irq_o,
  output logic [CNT_W-1:0] slave_compare_data_o,
  output logic [2:0] duty_step_o,
  output logic indicator_port_pin_o,
  output logic indicator_port_pin_oe_o,
  output logic running_o
);

  // Low width for a duty step: the pin is low for the complement of the
  // duty, so the lamp's brightness is that complement. [RULE14] [RULE16]
  function automatic logic [CNT_W-1:0] low_width(input msp_step_type s);
    int duty;
    duty = `MSP_DUTY_FIRST_PCT + `MSP_DUTY_STEP_PCT * int'(s);
    return CNT_W'((PERIOD_CYC * (`MSP_FULL_PCT - duty)) / `MSP_FULL_PCT);
  endfunction

  // Reset value of the compare: the 90% low width of the first step. It is a
  // constant so the asynchronous reset branch loads no computed value. [RULE6]
  localparam logic [CNT_W-1:0] CMP_RESET =
    CNT_W'((PERIOD_CYC * (`MSP_FULL_PCT - `MSP_DUTY_FIRST_PCT)) / `MSP_FULL_PCT);

  msp_state_type state; // Idle or running.
  msp_state_type next_state;
  logic [CNT_W-1:0] mcnt; // Master down-counter.
  logic [CNT_W-1:0] next_mcnt;
  logic [7:0] irq_cnt; // Period interrupts since the last update.
  logic [7:0] next_irq_cnt;
  msp_step_type step; // Current duty step.
  msp_step_type next_step;
  logic [CNT_W-1:0] cmp; // Slave compare data.
  logic [CNT_W-1:0] next_cmp;
  logic ind; // Indicator pin level.
  logic next_ind;
  logic ind_oe; // Indicator pin drive enable.
  logic irq; // Registered period interrupt pulse.
  logic next_irq;
  logic period_start; // Trigger to the slave, one cycle.
  logic duty_tick; // Duty update in this cycle.

  // Master timer, interrupt counter and duty stepper.
  always_comb begin
    next_state = state;
    next_mcnt = mcnt;
    next_irq_cnt = irq_cnt;
    next_step = step;
    next_cmp = cmp;
    next_ind = ind;
    next_irq = 1'b0;
    period_start = 1'b0;
    duty_tick = 1'b0;
    case (state)
      ST_IDLE: begin
        // Both channels start only from one joint write; a single bit
        // alone is ignored so the pair never runs out of step. [RULE7]
        if (run_trig_i == `MSP_TRIG_BOTH) begin
          next_state = ST_RUN;
          next_mcnt = CNT_W'(PERIOD_CYC - 1); // [RULE17]
          period_start = 1'b1; // [RULE2]
        end
      end
      ST_RUN: begin
        if (halt_i) begin
          // Halting keeps the duty step so a restart resumes it.
          next_state = ST_IDLE;
          next_mcnt = '0;
          next_irq_cnt = '0;
        end else if (mcnt == '0) begin
          // End of a pulse cycle: reload, interrupt, retrigger. [RULE1] [RULE8]
          next_mcnt = CNT_W'(PERIOD_CYC - 1);
          next_irq = 1'b1;
          period_start = 1'b1;
          if (irq_cnt == 8'(IRQ_PER_STEP - 1)) begin
            // Every 250th interrupt advances the duty. [RULE9]
            duty_tick = 1'b1;
            next_irq_cnt = '0;
            if (step == 3'(`MSP_DUTY_STEPS - 1)) begin
              next_step = '0; // [RULE11]
            end else begin
              next_step = step + 3'h1; // [RULE11]
            end
            next_cmp = low_width(next_step); // [RULE10]
            next_ind = ~ind; // [RULE12]
          end else begin
            next_irq_cnt = irq_cnt + 8'h01;
          end
        end else begin
          next_mcnt = mcnt - CNT_W'(1);
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  // Registers of the master side. The first compare is the 90% low width,
  // which is E100H when the period is 64000 counts. [RULE6] [RULE15]
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state <= ST_IDLE;
      mcnt <= '0;
      irq_cnt <= '0;
      step <= '0;
      cmp <= CMP_RESET;
      ind <= `MSP_IND_RESET;
      irq <= 1'b0;
    end else begin
      state <= next_state;
      mcnt <= next_mcnt;
      irq_cnt <= next_irq_cnt;
      step <= next_step;
      cmp <= next_cmp;
      ind <= next_ind;
      irq <= next_irq;
    end
  end

  // The indicator pin is set up as an output in the first cycle after
  // reset and stays so. [RULE13]
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ind_oe <= 1'b0;
    end else begin
      ind_oe <= 1'b1;
    end
  end

  // Slave channel; its pin is the PWM output. [RULE3]
  msp_slave_chan #(
    .CNT_W(CNT_W)
  ) msp_slave_chan_inst (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .run_i(next_state == ST_RUN),
    .trig_i(period_start),
    .cmp_i(cmp),
    .pin_o(pwm_out_pin_o)
  );

  assign master_period_irq_o = irq;
  assign slave_compare_data_o = cmp;
  assign duty_step_o = step;
  assign indicator_port_pin_o = ind;
  assign indicator_port_pin_oe_o = ind_oe;
  assign running_o = (state == ST_RUN);

  // Helper: cycles since the last period interrupt.
  logic [31:0] gap;
  logic seen;
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      gap <= '0;
      seen <= 1'b0;
    end else if (state != ST_RUN) begin
      gap <= '0;
      seen <= 1'b0;
    end else if (irq) begin
      gap <= '0;
      seen <= 1'b1;
    end else begin
      gap <= gap + 32'h1;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  AST_IRQ_SPACING: assert property ( // [RULE8]
    irq && seen && $past(state == ST_RUN) |-> gap == 32'(PERIOD_CYC - 1))
    else $error("Period interrupts are not one period apart.");

  AST_IDLE_HIGH: assert property ( // [RULE5]
    state == ST_IDLE && $past(state == ST_IDLE) |-> pwm_out_pin_o == `MSP_PIN_IDLE)
    else $error("PWM pin not inactive while stopped.");

  AST_JOINT_START: assert property ( // [RULE7]
    $rose(state == ST_RUN) |-> $past(run_trig_i) == `MSP_TRIG_BOTH)
    else $error("Channels started without both trigger bits.");

  AST_LOW_AFTER_START: assert property ( // [RULE4]
    period_start && !halt_i && cmp != '0 |=> pwm_out_pin_o == `MSP_PIN_ACTIVE)
    else $error("PWM pin not low after period start.");

  AST_STEP_ON_COUNT: assert property ( // [RULE9]
    duty_tick |-> irq_cnt == 8'(IRQ_PER_STEP - 1) ##1 irq_cnt == '0 && irq)
    else $error("Duty update not on the 250th interrupt.");

  AST_STEP_WRAP: assert property ( // [RULE11]
    duty_tick |=> step == (($past(step) == 3'(`MSP_DUTY_STEPS - 1)) ? 3'h0 : $past(step) + 3'h1))
    else $error("Duty step sequence broken.");

  AST_IND_TOGGLE: assert property ( // [RULE12]
    $changed(ind) |-> $past(duty_tick))
    else $error("Indicator changed without a duty update.");

  AST_CMP_MATCH: assert property ( // [RULE6]
    cmp == low_width(step))
    else $error("Compare value does not match the duty step.");

  CVR_FIRST_IRQ: cover property ($rose(irq));
  CVR_TICK: cover property (duty_tick);
  CVR_WRAP: cover property (duty_tick && step == 3'(`MSP_DUTY_STEPS - 1));
  CVR_HALT: cover property (state == ST_RUN && halt_i);
endmodule

`default_nettype wire

// ===== rtl/msp_slave_chan.sv
/*
  Slave channel in one-count mode: each trigger from the master drives the
  pin low for the latched compare count, then returns it high.
  Assumes triggers come from the master channel in the same clock domain.
*/
`include "msp_cfg.svh"
`default_nettype none

module msp_slave_chan
  import msp_pkg::*;
#(
  parameter int CNT_W = `MSP_CNT_W
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic run_i,
  input wire logic trig_i,
  input wire logic [CNT_W-1:0] cmp_i,
  output logic pin_o
);
  logic [CNT_W-1:0] lcnt; // Remaining low cycles.
  logic [CNT_W-1:0] next_lcnt;
  logic [CNT_W-1:0] lat; // Compare taken at the last trigger.
  logic [CNT_W-1:0] next_lat;
  logic pin;
  logic next_pin;

  // Next state of the one-count timer.
  always_comb begin
    next_lcnt = lcnt;
    next_lat = lat;
    next_pin = pin;
    if (!run_i) begin
      // Stopped: the pin rests at its inactive level.
      next_pin = `MSP_PIN_IDLE; // [RULE5]
      next_lcnt = '0;
    end else if (trig_i) begin
      // A new compare only takes hold here, so a mid-period write never
      // cuts a pulse short. [RULE16] [RULE2]
      next_lat = cmp_i;
      next_lcnt = cmp_i;
      next_pin = (cmp_i != '0) ? `MSP_PIN_ACTIVE : `MSP_PIN_IDLE; // [RULE4]
    end else if (pin == `MSP_PIN_ACTIVE) begin
      // Count out the low width, then release the pin.
      if (lcnt <= CNT_W'(1)) begin
        next_pin = `MSP_PIN_IDLE;
        next_lcnt = '0;
      end else begin
        next_lcnt = lcnt - CNT_W'(1);
      end
    end
  end

  // Registers of the one-count timer.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      lcnt <= '0;
      lat <= '0;
      pin <= `MSP_PIN_IDLE;
    end else begin
      lcnt <= next_lcnt;
      lat <= next_lat;
      pin <= next_pin;
    end
  end

  assign pin_o = pin;

  // Helper: low cycles seen since the last trigger.
  logic [CNT_W-1:0] low_len;
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      low_len <= '0;
    end else if (trig_i) begin
      low_len <= '0;
    end else if (pin == `MSP_PIN_ACTIVE) begin
      low_len <= low_len + CNT_W'(1);
    end
  end

  AST_LOW_WIDTH: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE16]
    $rose(pin) && run_i && $past(run_i) |-> low_len == lat)
    else $error("Low width differs from the compare value.");

  CVR_PULSE: cover property (@(posedge clk_i) disable iff (rst_i) $rose(pin) && run_i);
endmodule

`default_nettype wire

// ===== tb/msp_lamp_model.sv
/*
  Lamp on the PWM pin: lit while the pin is low, reports lit cycles per period.
  Assumes the period interrupt pulse marks the start of each period.
*/
`default_nettype none

module msp_lamp_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic pin_i,
  input wire logic period_i,
  output logic [17:0] lit_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [17:0] cnt; // Lit cycles in the running period.
  // The pin is active low, so lit time is the complement of the duty.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt <= 18'h0;
      lit_o <= 18'h0;
    end else if (period_i) begin
      // Latch the finished period and start counting the new one.
      lit_o <= cnt;
      cnt <= {17'h0, ~pin_i};
    end else begin
      cnt <= cnt + {17'h0, ~pin_i};
    end
  end
endmodule

`default_nettype wire

// ===== tb/msp_pwm_top_tb.sv
/*
  Self-checking bench of the PWM duty stepper with a lamp model on the pin.
  Assumes a shortened period and step count so the run stays short.
*/
`default_nettype none

module msp_pwm_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int PER = 100; // Shortened pulse cycle in clocks.
  localparam int STEPS = 3; // Shortened interrupts per duty update.
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [1:0] run_trig_i = 2'h0;
  logic halt_i = 1'b0;
  logic pin, irq, ind, oe, run;
  logic [17:0] cmp, lit;
  logic [2:0] step;
  int n_fail = 0;
  int tests_run = 0;
  int cycles = 0;
  int last_irq = 0;
  msp_pwm_top #(.PERIOD_CYC(PER), .CNT_W(18), .IRQ_PER_STEP(STEPS)) msp_pwm_top_inst (
    .clk_i(clk_i), .rst_i(rst_i), .run_trig_i(run_trig_i), .halt_i(halt_i),
    .pwm_out_pin_o(pin), .master_period_irq_o(irq), .slave_compare_data_o(cmp),
    .duty_step_o(step), .indicator_port_pin_o(ind), .indicator_port_pin_oe_o(oe), .running_o(run));
  msp_lamp_model msp_lamp_model_inst (.clk_i(clk_i), .rst_i(rst_i), .pin_i(pin), .period_i(irq), .lit_o(lit));
  // Free-running 100 MHz clock.
  initial begin
    forever #5 clk_i = ~clk_i;
  end
  // Cycle count; a hang past the ceiling ends the run as a failure.
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 6000) begin
      n_fail++;
      summarize();
    end
  end
  // Low width for duty index s; the sequence is 10 percent plus 20 per step.
  function automatic logic [17:0] low_w(input int s);
    return 18'(PER * (100 - (10 + 20 * s)) / 100);
  endfunction
  task automatic chk_lvl(input logic got, input logic exp, input string what);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: %s got %b expected %b", $time, what, got, exp);
    end
  endtask
  task automatic chk_num(input logic [17:0] got, input logic [17:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: %s got %0d expected %0d", $time, what, got, exp);
    end
  endtask
  // Wait for the next period pulse, bounded so a silent master cannot hang.
  task automatic wait_irq();
    int n;
    n = 0;
    do begin
      @(negedge clk_i);
      n++;
    end while (irq !== 1'b1 && n < 300);
    chk_lvl(irq, 1'b1, "period pulse");
  endtask
  // Joint trigger for one cycle, then check the pair started.
  task automatic start_pair();
    // Let one edge pass so the trigger never changes twice in one step.
    @(negedge clk_i);
    run_trig_i = 2'h3;
    @(negedge clk_i);
    run_trig_i = 2'h0;
    chk_lvl(run, 1'b1, "running after trigger");
    chk_lvl(pin, 1'b0, "pin low at start");
    last_irq = cycles;
  endtask
  task automatic t_reset();
    chk_lvl(oe, 1'b0, "indicator enable in reset");
    rst_i = 1'b0;
    @(negedge clk_i);
    chk_lvl(oe, 1'b1, "indicator enable");
    chk_lvl(pin, 1'b1, "idle pin");
    chk_num(cmp, low_w(0), "initial compare");
    chk_num(18'(step), 18'h0, "initial step");
    // A lone trigger bit must not start either channel.
    run_trig_i = 2'h1;
    @(negedge clk_i);
    run_trig_i = 2'h2;
    @(negedge clk_i);
    run_trig_i = 2'h0;
    chk_lvl(run, 1'b0, "partial trigger");
    chk_lvl(pin, 1'b1, "pin after partial trigger");
    $display("test reset done");
  endtask
  // Five updates walk the whole duty sequence and wrap back to the first.
  task automatic t_steps();
    start_pair();
    for (int k = 1; k <= 5; k++) begin
      for (int j = 1; j <= STEPS; j++) begin
        wait_irq();
        if (k == 1 && j == 1) begin
          chk_lvl(cycles - last_irq inside {PER, PER + 1}, 1'b1, "first period");
        end else begin
          chk_num(18'(cycles - last_irq), 18'(PER), "period length");
        end
        last_irq = cycles;
        if (j < STEPS) begin
          chk_num(18'(step), 18'((k - 1) % 5), "step held");
        end else begin
          chk_num(18'(step), 18'(k % 5), "step advanced");
          chk_num(cmp, low_w(k % 5), "new compare");
          chk_lvl(ind, 1'(k % 2), "indicator toggled");
        end
        @(negedge clk_i);
        // The lit count is the pulse begun at the previous period start, which
        // still used the step in force before that start took effect.
        chk_num(lit, low_w((j == 1 && k > 1) ? k - 2 : k - 1), "lit cycles");
      end
    end
    $display("test steps done");
  endtask
  // Halt stops the pair, keeps the step and clears the interrupt count.
  task automatic t_halt();
    logic quiet;
    wait_irq();
    halt_i = 1'b1;
    @(negedge clk_i);
    halt_i = 1'b0;
    chk_lvl(run, 1'b0, "halted");
    quiet = 1'b1;
    repeat (PER + 20) begin
      @(negedge clk_i);
      quiet = quiet & pin & ~irq;
    end
    chk_lvl(quiet, 1'b1, "idle after halt");
    chk_num(18'(step), 18'h0, "step kept");
    start_pair();
    for (int j = 1; j <= STEPS; j++) begin
      wait_irq();
      chk_num(18'(step), (j == STEPS) ? 18'h1 : 18'h0, "count restarted");
    end
    chk_lvl(ind, 1'b0, "indicator after restart");
    $display("test halt done");
  endtask
  task automatic summarize();
    $display("comparisons %0d, mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // Main sequence: reset for 12 cycles, then the scenarios in order.
  initial begin
    repeat (12) @(negedge clk_i);
    t_reset();
    t_steps();
    t_halt();
    summarize();
  end
endmodule

`default_nettype wire
